/* common/iph_params.svh */
/*
 constants for the i/o port, handshake and memory bus block.
 assumes a 100 MHz clock and an 8-bit AXI4-Lite byte address.
*/
`ifndef IPH_PARAMS_SVH
`define IPH_PARAMS_SVH

`define IPH_AXI_AW        8
`define IPH_ADDR_P0MODE   8'h00
`define IPH_ADDR_P0DATA   8'h04
`define IPH_ADDR_P2MODE   8'h08
`define IPH_ADDR_P2DATA   8'h0c
`define IPH_ADDR_GCFG     8'h10
`define IPH_ADDR_STATUS   8'h14
`define IPH_ADDR_MADDR    8'h18
`define IPH_ADDR_MDATA    8'h1c

`define IPH_P0_LOW_OUT    0
`define IPH_P0_HIGH_OUT   1
`define IPH_P0_LOW_ADDR   2
`define IPH_P0_HIGH_ADDR  3
`define IPH_P0_HS         4
`define IPH_P0_EXT        5
`define IPH_P0_HIZ        6
`define IPH_G_OPEN_DRAIN  0
`define IPH_G_LOW_EMI     1
`define IPH_G_P2_HS       2
`define IPH_M_WRITE       16

`define IPH_P0MODE_RST    7'h00
`define IPH_P0MODE_EXTPRG 7'h2c
`define IPH_P2MODE_RST    8'hff
`define IPH_GCFG_RST      3'h0

`define IPH_RESP_OKAY     2'b00
`define IPH_RESP_SLVERR   2'b10

`define IPH_CLK_NS        10
`define IPH_DAV_SETUP_NS  42
`define IPH_DAV_SETUP_CYC ((`IPH_DAV_SETUP_NS+`IPH_CLK_NS-1)/`IPH_CLK_NS)
`define IPH_DS_CYC        2
`define IPH_EXT_CYC       2
`define IPH_RST_STB_CYC   8

`endif

/* common/iph_pkg.sv */
/*
 types for the i/o port, handshake and memory bus block.
 assumes the constants header is included by the design file.
*/
package iph_pkg;
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_SETUP = 2'b01,
		HS_WAIT  = 2'b10,
		HS_DONE  = 2'b11
	} iph_hs_state_t;

	typedef enum logic [2:0] {
		MB_RESET = 3'b000,
		MB_IDLE  = 3'b001,
		MB_ADDR  = 3'b010,
		MB_HOLD  = 3'b011,
		MB_DATA  = 3'b100
	} iph_mb_state_t;

	typedef struct packed {
		logic addressStrobeN;
		logic dataStrobeN;
		logic readWriteN;
	} iph_strobes_t;
endpackage

/* src/iph_ports.sv */
/*
 two 8-bit i/o ports with strobed handshake, external memory strobes
 and an AXI4-Lite register slave. assumes all pin inputs are already
 synchronous to clock and that the pad ring resolves the three-signal
 pins (output enable low while driving).
*/
`include "iph_params.svh"
`timescale 1ns/100ps
`default_nettype none

module iph_handshake (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// control
	input  wire logic       enable,
	input  wire logic       outMode,
	input  wire logic       writeStrobe,
	input  wire logic [7:0] writeData,
	input  wire logic       readStrobe,
	// pins
	input  wire logic [7:0] pinsIn,
	input  wire logic       davIn_n,
	input  wire logic       readyIn,
	output logic            davOut_n,
	output logic            readyOut,
	// state
	output logic [7:0]      dataOut,
	output logic [7:0]      rxData,
	output logic            busy,
	output logic            full
);
	iph_pkg::iph_hs_state_t state_reg, state_next;
	logic [7:0] data_reg, data_next;
	logic [7:0] rx_reg, rx_next;
	logic [3:0] cnt_reg, cnt_next;

	always_comb begin
		state_next = state_reg;
		data_next = data_reg;
		rx_next = rx_reg;
		cnt_next = cnt_reg;
		if (writeStrobe && state_reg == iph_pkg::HS_IDLE)
			data_next = writeData;
		case (state_reg)
		iph_pkg::HS_IDLE: begin
			cnt_next = 4'h0;
			if (enable && outMode && writeStrobe)
				state_next = iph_pkg::HS_SETUP;
			else if (enable && !outMode && !davIn_n) begin
				rx_next = pinsIn;
				state_next = iph_pkg::HS_WAIT;
			end
		end
		iph_pkg::HS_SETUP: begin
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg == 4'(`IPH_DAV_SETUP_CYC - 1))
				state_next = iph_pkg::HS_WAIT;
		end
		iph_pkg::HS_WAIT: begin
			if (outMode && !readyIn)
				state_next = iph_pkg::HS_DONE;
			else if (!outMode && readStrobe)
				state_next = iph_pkg::HS_DONE;
		end
		iph_pkg::HS_DONE: begin
			if (outMode ? readyIn : davIn_n)
				state_next = iph_pkg::HS_IDLE;
		end
		default: state_next = iph_pkg::HS_IDLE;
		endcase
		if (!enable)
			state_next = iph_pkg::HS_IDLE;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= iph_pkg::HS_IDLE;
			data_reg <= 8'h00;
			rx_reg <= 8'h00;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			data_reg <= data_next;
			rx_reg <= rx_next;
			cnt_reg <= cnt_next;
		end
	end

	// ready falls in the same cycle as data-available, no clock lag
	assign readyOut = state_reg == iph_pkg::HS_IDLE && davIn_n;
	assign davOut_n = !(outMode && state_reg == iph_pkg::HS_WAIT);
	assign dataOut = data_reg;
	assign rxData = rx_reg;
	assign busy = outMode && state_reg != iph_pkg::HS_IDLE;
	assign full = !outMode && state_reg == iph_pkg::HS_WAIT;
endmodule

module iph_ports (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	// chip control
	input  wire logic                   external_program_select_n,
	input  wire logic                   stopRecovery,
	// axi4-lite slave
	input  wire logic [`IPH_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`IPH_AXI_AW-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// first port pins
	input  wire logic [7:0]             firstPortIn,
	output logic [7:0]                  firstPortOut,
	output logic [7:0]                  firstPortOe_n,
	// second port pins
	input  wire logic [7:0]             secondPortIn,
	output logic [7:0]                  secondPortOut,
	output logic [7:0]                  secondPortOe_n,
	// port 3 handshake lines 1, 2, 5, 6
	input  wire logic [3:0]             port3In,
	output logic [3:0]                  port3Out,
	output logic [3:0]                  port3Oe_n,
	// external memory bus (port 1 and strobes)
	input  wire logic [7:0]             port1In,
	output logic [7:0]                  port1Out,
	output logic [7:0]                  port1Oe_n,
	output iph_pkg::iph_strobes_t       strobes,
	output logic                        strobesOe_n,
	output logic                        lowEmission
);
	// oe low drives; open drain releases ones
	function automatic logic [7:0] driveOeN(input logic [7:0] outEn,
			input logic [7:0] val, input logic od, input logic hiz);
		driveOeN = ~outEn | (od ? val : 8'h00) | {8{hiz}};
	endfunction

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] st);
		for (int i = 0; i < 4; i++)
			mergeBytes[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// register file and bus state
	logic [6:0]  p0mode_reg, p0mode_next;
	logic [7:0]  p2mode_reg, p2mode_next;
	logic [2:0]  gcfg_reg, gcfg_next;
	logic [16:0] maddr_reg, maddr_next;
	logic [7:0]  mdata_reg, mdata_next;
	logic        awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [7:0]  awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0]  ws_reg, ws_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	iph_pkg::iph_mb_state_t mb_reg, mb_next;
	logic [3:0]  mcnt_reg, mcnt_next;

	logic        doWrite, doRead, memStart, p0Read, p2Read;
	logic        wP0, wP2;
	logic [31:0] merged, rdMux, maddrMerged;
	logic [7:0]  p0Data, p0Rx, p2Data, p2Rx;
	logic        p0Busy, p0Full, p2Busy, p2Full;
	logic        hs0, hs2, out0, out2;
	logic [7:0]  p0OutEn, p0Val;
	logic        hiz;

	assign hs0 = p0mode_reg[`IPH_P0_HS];
	assign out0 = p0mode_reg[`IPH_P0_HIGH_OUT];
	assign hs2 = gcfg_reg[`IPH_G_P2_HS];
	assign out2 = !p2mode_reg[7];
	assign hiz = p0mode_reg[`IPH_P0_HIZ];

	assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign merged = mergeBytes(32'h0, wd_reg, ws_reg);
	assign maddrMerged = mergeBytes({15'h0, maddr_reg}, wd_reg, ws_reg);
	assign wP0 = doWrite && awa_reg == `IPH_ADDR_P0DATA && ws_reg[0];
	assign wP2 = doWrite && awa_reg == `IPH_ADDR_P2DATA && ws_reg[0];
	assign memStart = doWrite && awa_reg == `IPH_ADDR_MADDR &&
		mb_reg == iph_pkg::MB_IDLE;
	assign p0Read = doRead && s_axi_araddr == `IPH_ADDR_P0DATA;
	assign p2Read = doRead && s_axi_araddr == `IPH_ADDR_P2DATA;

	always_comb begin
		case (s_axi_araddr)
		`IPH_ADDR_P0MODE: rdMux = {25'h0, p0mode_reg};
		`IPH_ADDR_P0DATA: rdMux = {24'h0, hs0 && !out0 ? p0Rx : firstPortIn};
		`IPH_ADDR_P2MODE: rdMux = {24'h0, p2mode_reg};
		`IPH_ADDR_P2DATA: rdMux = {24'h0, hs2 && !out2 ? p2Rx : secondPortIn};
		`IPH_ADDR_GCFG:   rdMux = {29'h0, gcfg_reg};
		`IPH_ADDR_STATUS: rdMux = {26'h0, mb_reg == iph_pkg::MB_RESET,
			mb_reg != iph_pkg::MB_IDLE, p2Full, p2Busy, p0Full, p0Busy};
		`IPH_ADDR_MADDR:  rdMux = {15'h0, maddr_reg};
		`IPH_ADDR_MDATA:  rdMux = {24'h0, mdata_reg};
		default:          rdMux = 32'h0;
		endcase
	end

	// bus slave; address and data may arrive in either order
	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next = wHeld_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (doWrite) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (awa_reg > `IPH_ADDR_MDATA || awa_reg[1:0] != 2'b00)
				? `IPH_RESP_SLVERR : `IPH_RESP_OKAY;
		end else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (doRead) begin
			rvalid_next = 1'b1;
			rdata_next = rdMux;
			rresp_next = (s_axi_araddr > `IPH_ADDR_MDATA ||
				s_axi_araddr[1:0] != 2'b00) ? `IPH_RESP_SLVERR
				: `IPH_RESP_OKAY;
		end else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	// configuration registers, strap and stop recovery
	always_comb begin
		p0mode_next = p0mode_reg;
		p2mode_next = p2mode_reg;
		gcfg_next = gcfg_reg;
		maddr_next = maddr_reg;
		if (doWrite && awa_reg == `IPH_ADDR_P0MODE && ws_reg[0])
			p0mode_next = merged[6:0];
		if (doWrite && awa_reg == `IPH_ADDR_P2MODE && ws_reg[0])
			p2mode_next = merged[7:0];
		if (doWrite && awa_reg == `IPH_ADDR_GCFG && ws_reg[0])
			gcfg_next = merged[2:0];
		if (memStart)
			maddr_next = maddrMerged[16:0];
		// strap is sampled on the last reset strobe cycle
		if (mb_reg == iph_pkg::MB_RESET &&
				mcnt_reg == 4'(`IPH_RST_STB_CYC - 1))
			p0mode_next = external_program_select_n ? `IPH_P0MODE_RST
				: `IPH_P0MODE_EXTPRG;
		// only the first port setup returns to reset state
		if (stopRecovery)
			p0mode_next = `IPH_P0MODE_RST;
	end

	// memory bus sequencer
	always_comb begin
		mb_next = mb_reg;
		mcnt_next = mcnt_reg + 4'h1;
		mdata_next = mdata_reg;
		if (doWrite && awa_reg == `IPH_ADDR_MDATA && ws_reg[0] &&
				mb_reg == iph_pkg::MB_IDLE)
			mdata_next = merged[7:0];
		case (mb_reg)
		iph_pkg::MB_RESET:
			if (mcnt_reg == 4'(`IPH_RST_STB_CYC - 1))
				mb_next = iph_pkg::MB_IDLE;
		iph_pkg::MB_IDLE: begin
			mcnt_next = 4'h0;
			if (memStart)
				mb_next = iph_pkg::MB_ADDR;
		end
		iph_pkg::MB_ADDR: begin
			mcnt_next = 4'h0;
			mb_next = iph_pkg::MB_HOLD;
		end
		iph_pkg::MB_HOLD: begin
			mcnt_next = 4'h0;
			mb_next = iph_pkg::MB_DATA;
		end
		iph_pkg::MB_DATA: begin
			// extended timing stretches the strobe for slow memory
			if (mcnt_reg == (p0mode_reg[`IPH_P0_EXT]
					? 4'(`IPH_DS_CYC + `IPH_EXT_CYC - 1)
					: 4'(`IPH_DS_CYC - 1))) begin
				mb_next = iph_pkg::MB_IDLE;
				if (!maddr_reg[`IPH_M_WRITE])
					mdata_next = port1In;
			end
		end
		default: mb_next = iph_pkg::MB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			p0mode_reg <= `IPH_P0MODE_RST;
			p2mode_reg <= `IPH_P2MODE_RST;
			gcfg_reg <= `IPH_GCFG_RST;
			maddr_reg <= 17'h0;
			mdata_reg <= 8'h00;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0;
			ws_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `IPH_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `IPH_RESP_OKAY;
			rdata_reg <= 32'h0;
			mb_reg <= iph_pkg::MB_RESET;
			mcnt_reg <= 4'h0;
		end else begin
			p0mode_reg <= p0mode_next;
			p2mode_reg <= p2mode_next;
			gcfg_reg <= gcfg_next;
			maddr_reg <= maddr_next;
			mdata_reg <= mdata_next;
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			mb_reg <= mb_next;
			mcnt_reg <= mcnt_next;
		end
	end

	assign s_axi_awready = !awHeld_reg && !bvalid_reg;
	assign s_axi_wready = !wHeld_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	iph_handshake firstChannel (
		.clock       (clock),
		.reset_n     (reset_n),
		.enable      (hs0),
		.outMode     (out0),
		.writeStrobe (wP0),
		.writeData   (merged[7:0]),
		.readStrobe  (p0Read),
		.pinsIn      (firstPortIn),
		.davIn_n     (port3In[1]),
		.readyIn     (port3In[2]),
		.davOut_n    (port3Out[1]),
		.readyOut    (port3Out[2]),
		.dataOut     (p0Data),
		.rxData      (p0Rx),
		.busy        (p0Busy),
		.full        (p0Full)
	);

	iph_handshake secondChannel (
		.clock       (clock),
		.reset_n     (reset_n),
		.enable      (hs2),
		.outMode     (out2),
		.writeStrobe (wP2),
		.writeData   (merged[7:0]),
		.readStrobe  (p2Read),
		.pinsIn      (secondPortIn),
		.davIn_n     (port3In[0]),
		.readyIn     (port3In[3]),
		.davOut_n    (port3Out[0]),
		.readyOut    (port3Out[3]),
		.dataOut     (p2Data),
		.rxData      (p2Rx),
		.busy        (p2Busy),
		.full        (p2Full)
	);

	// bit order: 0 line1, 1 line2, 2 line5, 3 line6
	assign port3Oe_n = {!(hs2 && !out2), !(hs0 && !out0),
		!(hs0 && out0), !(hs2 && out2)};

	assign p0OutEn = {{4{p0mode_reg[`IPH_P0_HIGH_OUT] ||
		p0mode_reg[`IPH_P0_HIGH_ADDR]}}, {4{p0mode_reg[`IPH_P0_LOW_OUT] ||
		p0mode_reg[`IPH_P0_LOW_ADDR]}}};
	assign p0Val = {p0mode_reg[`IPH_P0_HIGH_ADDR] ? maddr_reg[15:12]
		: p0Data[7:4], p0mode_reg[`IPH_P0_LOW_ADDR] ? maddr_reg[11:8]
		: p0Data[3:0]};
	assign firstPortOut = p0Val;
	assign firstPortOe_n = driveOeN(p0OutEn, p0Val,
		gcfg_reg[`IPH_G_OPEN_DRAIN], hiz);
	assign secondPortOut = p2Data;
	assign secondPortOe_n = driveOeN(~p2mode_reg, p2Data,
		gcfg_reg[`IPH_G_OPEN_DRAIN], 1'b0);
	assign lowEmission = gcfg_reg[`IPH_G_LOW_EMI];

	// port 1 carries the low address then write data
	assign port1Out = mb_reg == iph_pkg::MB_DATA ? mdata_reg
		: maddr_reg[7:0];
	assign port1Oe_n = {8{hiz || !(mb_reg == iph_pkg::MB_ADDR ||
		mb_reg == iph_pkg::MB_HOLD || (mb_reg == iph_pkg::MB_DATA &&
		maddr_reg[`IPH_M_WRITE]))}};
	assign strobes.addressStrobeN = mb_reg == iph_pkg::MB_RESET
		? mcnt_reg[0] : mb_reg != iph_pkg::MB_ADDR;
	assign strobes.dataStrobeN = mb_reg != iph_pkg::MB_RESET &&
		mb_reg != iph_pkg::MB_DATA;
	assign strobes.readWriteN = !(maddr_reg[`IPH_M_WRITE] &&
		(mb_reg == iph_pkg::MB_HOLD || mb_reg == iph_pkg::MB_DATA));
	assign strobesOe_n = hiz;
endmodule

`default_nettype wire

/* testbench/iph_ports_checker.sv */
/* pin-level assertions for iph_ports.
 assumes one clock and an async active-low reset; bound from the bench. */
`timescale 1ns/100ps
`default_nettype none
module iph_ports_checker (
	// clock and reset
	input wire logic                  clock,
	input wire logic                  reset_n,
	// memory bus
	input wire iph_pkg::iph_strobes_t strobes,
	input wire logic                  strobesOe_n,
	input wire logic [7:0]            port1Oe_n,
	// handshake lines
	input wire logic [3:0]            port3In,
	input wire logic [3:0]            port3Out,
	input wire logic [3:0]            port3Oe_n
);
	logic [3:0] ageReg;
	logic [3:0] ageNext;
	logic       run;
	logic       aStb;
	logic       dStb;
	logic       rwN;
	assign aStb = strobes.addressStrobeN;
	assign dStb = strobes.dataStrobeN;
	assign rwN = strobes.readWriteN;
	// saturating age keeps the reset strobe phase apart from transfers
	assign run = (ageReg == 4'hf);
	always_comb ageNext = run ? ageReg : ageReg + 4'h1;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ageReg <= 4'h0;
		else
			ageReg <= ageNext;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_reset_dstrobe: assert property (ageReg < 4'h7 |-> !dStb)
		else $error("data strobe high in reset phase");
	a_reset_toggle: assert property (
		ageReg inside {[4'h1:4'h6]} |-> aStb != $past(aStb))
		else $error("address strobe not toggling in reset phase");
	a_as_pulse: assert property (run && $fell(aStb) |=> aStb)
		else $error("address strobe pulse too long");
	a_ds_order: assert property (
		run && $fell(dStb) |-> !$past(aStb, 2))
		else $error("data strobe without address strobe");
	a_ds_width: assert property (
		run && $fell(dStb) |=> !dStb ##[1:4] dStb)
		else $error("data strobe width wrong");
	a_rw_write: assert property (run && $fell(rwN) |=> !dStb)
		else $error("write level without data strobe");
	a_hiz_float: assert property (strobesOe_n |-> port1Oe_n == 8'hff)
		else $error("bus driven while strobes float");
	a_dav_drop: assert property (
		!port3Oe_n[1] && !port3Out[1] && $fell(port3In[2])
		|-> ##[1:16] port3Out[1])
		else $error("data valid not dropped after ready");
	a_dav_wait: assert property (
		!port3Oe_n[1] && !port3In[2] && port3Out[1] |=> port3Out[1])
		else $error("data valid back while ready low");
	a_ready_drop: assert property (
		!port3Oe_n[3] && $fell(port3In[0]) |-> !port3Out[3])
		else $error("ready high on data valid fall");
	a_ready_hold: assert property (
		!port3Oe_n[3] && !port3In[0] |-> !port3Out[3])
		else $error("ready high while data valid low");
	cover property (run && $fell(dStb));
	cover property (!port3Oe_n[1] && $fell(port3In[2]));
	cover property (!port3Oe_n[3] && $fell(port3In[0]));
endmodule
`default_nettype wire

/* testbench/iph_far_side.sv */
/* far side: external memory and handshake peer of both ports.
 assumes resolved pin levels; released lines show a changing pattern, except second port lines, which hold the sender byte. */
`timescale 1ns/100ps
`default_nettype none
module iph_far_side (
	// clock
	input wire logic                  clock,
	// board lines
	input wire iph_pkg::iph_strobes_t strobes,
	input wire logic [7:0]            firstPortLine,
	input wire logic [7:0]            p1Line,
	input wire logic [3:0]            p3Line,
	// bench control
	input wire logic                  slowAck,
	input wire logic                  sendReq,
	input wire logic [7:0]            sendByte,
	output logic                      txBusy,
	// drives toward the device
	output logic [7:0]                p0Drive,
	output logic [7:0]                p1Drive,
	output logic [7:0]                p2Drive,
	output logic [3:0]                p3Drive,
	// observation
	output logic [15:0]               lastAddr,
	output logic [7:0]                memLast,
	output logic [7:0]                gotByte,
	output logic [7:0]                gotCount
);
	logic [7:0] mem [0:255];
	logic [7:0] tgl;
	logic       rdyA;
	logic       davB;
	logic [2:0] hold;
	logic [1:0] txState;
	initial begin
		for (int k = 0; k < 256; k++) mem[k] = 8'(k);
		tgl = 8'h5a;
		rdyA = 1'b1;
		davB = 1'b1;
		hold = 3'h0;
		txState = 2'h0;
		gotCount = 8'h0;
		p2Drive = 8'h00;
	end
	assign p0Drive = tgl;
	// read data only while strobed, else a pattern so stale data never passes
	assign p1Drive = (!strobes.dataStrobeN && strobes.readWriteN)
		? mem[lastAddr[7:0]] : tgl;
	assign p3Drive = {tgl[3], rdyA, tgl[1], davB};
	assign txBusy = (txState != 2'h0);
	always @(posedge clock) begin
		tgl <= ~tgl;
		if (!strobes.addressStrobeN) lastAddr <= {firstPortLine, p1Line};
		if (!strobes.dataStrobeN && !strobes.readWriteN) begin
			mem[lastAddr[7:0]] <= p1Line;
			memLast <= p1Line;
		end
		// receiver on the first port: slow mode holds ready low longer
		if (rdyA && !p3Line[1]) begin
			gotByte <= firstPortLine;
			gotCount <= gotCount + 8'h1;
			rdyA <= 1'b0;
			hold <= slowAck ? 3'h5 : 3'h0;
		end else if (!rdyA && p3Line[1]) begin
			if (hold == 3'h0) rdyA <= 1'b1;
			else hold <= hold - 3'h1;
		end
		// sender on the second port
		case (txState)
			2'h0: if (sendReq) begin
				p2Drive <= sendByte;
				txState <= 2'h1;
			end
			2'h1: begin
				davB <= 1'b0;
				txState <= 2'h2;
			end
			2'h2: if (!p3Line[3]) begin
				davB <= 1'b1;
				p2Drive <= ~p2Drive;
				txState <= 2'h3;
			end
			default: if (p3Line[3]) txState <= 2'h0;
		endcase
	end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
/* self-checking bench for iph_ports with far-side model and checker.
 assumes the package, header and design are compiled first. */
`include "iph_params.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clock, reset_n, stopRecovery, extSel_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, strobesOe_n, lowEmission;
	logic [7:0] firstPortIn, firstPortOut, firstPortOe_n, p0Drive;
	logic [7:0] secondPortIn, secondPortOut, secondPortOe_n, p2Drive;
	logic [7:0] port1In, port1Out, port1Oe_n, p1Drive;
	logic [3:0] port3In, port3Out, port3Oe_n, p3Drive;
	logic slowAck, sendReq, txBusy;
	logic [7:0] sendByte, memLast, gotByte, gotCount;
	logic [15:0] lastAddr;
	iph_pkg::iph_strobes_t strobes;
	logic [33:0] expQ[$], mskQ[$];
	int errors, checkCount, cycles;
	// the far side sees each line as resolved from both drivers
	assign firstPortIn = (firstPortOut & ~firstPortOe_n)
		| (p0Drive & firstPortOe_n);
	assign secondPortIn = (secondPortOut & ~secondPortOe_n)
		| (p2Drive & secondPortOe_n);
	assign port1In = (port1Out & ~port1Oe_n) | (p1Drive & port1Oe_n);
	assign port3In = (port3Out & ~port3Oe_n) | (p3Drive & port3Oe_n);
	iph_ports uut (.clock, .reset_n, .external_program_select_n(extSel_n),
		.stopRecovery, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .firstPortIn, .firstPortOut,
		.firstPortOe_n, .secondPortIn, .secondPortOut, .secondPortOe_n,
		.port3In, .port3Out, .port3Oe_n, .port1In, .port1Out, .port1Oe_n,
		.strobes, .strobesOe_n, .lowEmission);
	iph_far_side far (.clock, .strobes, .firstPortLine(firstPortIn),
		.p1Line(port1In), .p3Line(port3In), .slowAck, .sendReq, .sendByte,
		.txBusy, .p0Drive, .p1Drive, .p2Drive, .p3Drive, .lastAddr,
		.memLast, .gotByte, .gotCount);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
		check({26'h0, seen}, {26'h0, exp});
	endtask
	task automatic take(input logic [33:0] v);
		logic [33:0] m;
		m = mskQ.pop_front();
		check(v & m, expQ.pop_front() & m);
	endtask
	// every result is checked in arrival order against the oldest note
	always @(posedge clock) begin
		if ({s_axi_bvalid, s_axi_bready} === 2'b11)
			take({s_axi_bresp, 32'h0});
		if ({s_axi_rvalid, s_axi_rready} === 2'b11)
			take({s_axi_rresp, s_axi_rdata});
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		expQ.push_back({r, 32'h0});
		mskQ.push_back(34'h3_0000_0000);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e,
		input logic [7:0] m);
		expQ.push_back(e);
		mskQ.push_back({2'b11, 24'h0, m});
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task automatic mem_wait;
		wait (strobes.dataStrobeN === 1'b0);
		wait (strobes.dataStrobeN === 1'b1);
		@(posedge clock);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end
	bit [1:0] OK;
	assign OK = `IPH_RESP_OKAY;
	initial begin
		int i;
		logic [15:0] adr;
		logic [7:0] dat;
		logic [7:0] n;
		{reset_n, stopRecovery, extSel_n, slowAck, sendReq, sendByte} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(16605));
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		repeat (12) @(posedge clock);
		axi_rd(`IPH_ADDR_P0MODE, 34'h2c, 8'hff);
		axi_rd(`IPH_ADDR_P2MODE, 34'hff, 8'hff);
		axi_rd(`IPH_ADDR_GCFG, 34'h0, 8'hff);
		axi_wr(8'h20, 32'h1, `IPH_RESP_SLVERR);
		axi_rd(8'h24, {`IPH_RESP_SLVERR, 32'h0}, 8'hff);
		done("reset");
		for (i = 0; i < 2; i++) begin
			adr = 16'($urandom);
			dat = 8'($urandom);
			if (i == 1) axi_wr(`IPH_ADDR_P0MODE, 32'h0c, OK);
			axi_wr(`IPH_ADDR_MDATA, {24'h0, dat}, OK);
			axi_wr(`IPH_ADDR_MADDR, {15'h0, 1'b1, adr}, OK);
			mem_wait();
			check({18'h0, lastAddr}, {18'h0, adr});
			chk8(memLast, dat);
			axi_wr(`IPH_ADDR_MADDR, {16'h0, adr}, OK);
			mem_wait();
			axi_rd(`IPH_ADDR_MDATA, {26'h0, dat}, 8'hff);
		end
		done("memory");
		axi_wr(`IPH_ADDR_P0MODE, 32'h4c, OK);
		@(posedge clock);
		chk8({7'h0, strobesOe_n}, 8'h01);
		chk8(port1Oe_n & firstPortOe_n, 8'hff);
		axi_wr(`IPH_ADDR_P0MODE, 32'h13, OK);
		@(posedge clock);
		chk8(firstPortOe_n, 8'h00);
		chk8({7'h0, port3Oe_n[1]}, 8'h00);
		for (i = 0; i < 2; i++) begin
			slowAck <= (i == 1);
			dat = 8'($urandom);
			n = gotCount;
			axi_wr(`IPH_ADDR_P0DATA, {24'h0, dat}, OK);
			axi_wr(`IPH_ADDR_P0DATA, {24'h0, ~dat}, OK);
			wait (gotCount !== n);
			wait (port3In[2] === 1'b1 && port3Out[1] === 1'b1);
			@(posedge clock);
			chk8(gotByte, dat);
		end
		done("handshake out");
		axi_wr(`IPH_ADDR_GCFG, 32'h4, OK);
		for (i = 0; i < 2; i++) begin
			dat = 8'($urandom);
			sendByte <= dat;
			sendReq <= 1'b1;
			@(posedge clock);
			sendReq <= 1'b0;
			wait (port3In[3] === 1'b0);
			@(posedge clock);
			axi_rd(`IPH_ADDR_P2DATA, {26'h0, dat}, 8'hff);
			wait (txBusy === 1'b0);
			@(posedge clock);
			chk8({7'h0, port3In[3]}, 8'h01);
		end
		done("handshake in");
		axi_wr(`IPH_ADDR_GCFG, 32'h3, OK);
		axi_wr(`IPH_ADDR_P2MODE, 32'hf0, OK);
		axi_wr(`IPH_ADDR_P2DATA, 32'h5a, OK);
		@(posedge clock);
		chk8(secondPortOe_n, 8'hfa);
		chk8({7'h0, lowEmission}, 8'h01);
		axi_wr(`IPH_ADDR_GCFG, 32'h2, OK);
		@(posedge clock);
		chk8(secondPortOe_n, 8'hf0);
		chk8({4'h0, secondPortOut[3:0]}, 8'h0a);
		stopRecovery <= 1'b1;
		@(posedge clock);
		stopRecovery <= 1'b0;
		axi_rd(`IPH_ADDR_P2MODE, 34'hf0, 8'hff);
		axi_rd(`IPH_ADDR_GCFG, 34'h2, 8'hff);
		done("second port");
		repeat (4) @(posedge clock);
		close_out();
	end
endmodule
bind iph_ports iph_ports_checker chk (.clock, .reset_n, .strobes,
	.strobesOe_n, .port1Oe_n, .port3In, .port3Out, .port3Oe_n);
`default_nettype wire
